// ---- hw/vref_pkg.sv ----
// Shared constants and types for the fixed voltage reference control block.
// Assumes a single 50 MHz clock and an APB master with 32-bit data.
package vref_pkg;

  // Register byte addresses on the APB window.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CFG  = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;

  // Control register field positions.
  localparam int CTRL_READY_BIT = 7;
  localparam int CTRL_EN_BIT    = 6;
  localparam int CTRL_TS_BIT    = 5;
  localparam int CTRL_RNG_BIT   = 4;
  localparam int CTRL_GAIN_LSB  = 0;
  localparam int CTRL_GAP_LSB   = 2;

  // Configuration register field positions.
  localparam int CFG_BOR_LSB = 0;
  localparam int CFG_FAST_BIT = 2;
  localparam int CFG_PS_BIT   = 3;

  // Status register bit positions; the status word mirrors the live demand for debug.
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_SW_BIT     = 1;
  localparam int STAT_BOR_BIT    = 2;
  localparam int STAT_REG_BIT    = 3;
  localparam int STAT_PS_BIT     = 4;
  localparam int STAT_ROUTE_BIT  = 5;

  // Reset values and the ready flag level, which is always set on this part.
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [3:0] CFG_RESET   = 4'h0;
  localparam logic       READY_LEVEL = 1'b1;

  // Brown-out enable configuration codes that need the reference.
  localparam logic [1:0] BOR_SW_CTRL  = 2'h1;
  localparam logic [1:0] BOR_NO_SLEEP = 2'h2;
  localparam logic [1:0] BOR_ALWAYS   = 2'h3;

  // Reference output gain toward the ADC, in register code order.
  typedef enum logic [1:0] {
    GAIN_OFF,
    GAIN_1X,
    GAIN_2X,
    GAIN_4X
  } vref_gain_t;

  // Software control fields.
  typedef struct packed {
    logic       ref_enable;
    logic       temp_sense_enable;
    logic       temp_range_select;
    vref_gain_t gain;
  } vref_ctrl_t;

  // Brown-out and regulator configuration.
  typedef struct packed {
    logic [1:0] brownout_enable_cfg;
    logic       brownout_fast_start;
    logic       regulator_powersave_select;
  } vref_cfg_t;

  // Reasons for the reference to be on.
  typedef struct packed {
    logic sw;
    logic brownout;
    logic regulator;
  } vref_demand_t;

endpackage : vref_pkg

// ---- hw/vref_demand.sv ----
// Combines every requester of the fixed reference into one demand vector.
// Assumes its inputs are already on the core clock; it holds no state.
module vref_demand (
  input  wire vref_pkg::vref_ctrl_t   ctrl,
  input  wire vref_pkg::vref_cfg_t    cfg,
  input  wire logic                   sleep_mode,
  output      vref_pkg::vref_demand_t demand,
  output      logic                   use_powersave
);

  // Software request follows the enable bit directly.
  assign demand.sw = ctrl.ref_enable;

  // Brown-out detection needs the reference in the always-on mode, or with fast start in the off-in-sleep or software-control modes.
  assign demand.brownout =
      (cfg.brownout_enable_cfg == vref_pkg::BOR_ALWAYS) ||
      ((cfg.brownout_enable_cfg == vref_pkg::BOR_NO_SLEEP) && cfg.brownout_fast_start) ||
      ((cfg.brownout_enable_cfg == vref_pkg::BOR_SW_CTRL) && cfg.brownout_fast_start);

  // The main regulator path leans on the reference only while awake.
  assign demand.regulator = cfg.regulator_powersave_select && !sleep_mode;

  // In sleep the core runs from the power-save regulator.
  assign use_powersave = sleep_mode;

endmodule : vref_demand

// ---- hw/vref_ctrl.sv ----
// Fixed voltage reference control: APB register bank, demand merge and analog controls.
// Assumes a synchronous active-high reset, sleep and ADC channel inputs on the same clock.
// Function
// - The reference is on while the software enable bit is one and off when it is zero, unless forced.
// - Brown-out set always-on, or off-in-sleep with fast start, keeps the reference active.
// - Brown-out under software control with fast start also keeps the reference active.
// - The regulator keeps the reference active when power-save select is one and not in sleep.
// - In sleep the device runs from the power-save regulator instead of the main path.
// - The reference output is routed to its ADC input channel so software can measure it.
// - Control bits from 7 down are ready, enable, temperature enable, range, with gain in 1:0.
// - Control bits 3 and 2 read as zero and ignore writes.
// - The temperature indicator is enabled only while its enable bit is set.
// - Range select one picks the high indicator range, zero the low range.
module vref_ctrl #(
  parameter logic [3:0] ADC_REF_CHANNEL = 4'hF
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              sleep_mode,
  input  wire logic [3:0]        adc_chan_sel,
  output      logic              ref_active,
  output      logic              ref_out_en,
  output      vref_pkg::vref_gain_t ref_gain,
  output      logic              adc_ref_route,
  output      logic              temp_sense_on,
  output      logic              temp_range_high,
  output      logic              powersave_reg_sel
);

  vref_pkg::vref_ctrl_t   ctrl_r;
  vref_pkg::vref_cfg_t    cfg_r;
  vref_pkg::vref_demand_t demand;
  logic                   use_ps;
  logic                   pready_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  logic [31:0]            rdata_nxt;
  logic                   mapped;
  logic                   wr_done;
  logic                   ref_active_r;
  logic                   ref_out_en_r;
  vref_pkg::vref_gain_t   ref_gain_r;
  logic                   adc_ref_route_r;
  logic                   temp_sense_on_r;
  logic                   temp_range_high_r;
  logic                   powersave_r;

  // Demand merge lives in its own small module so the conditions read in one place.
  vref_demand u_demand (
    .ctrl          (ctrl_r),
    .cfg           (cfg_r),
    .sleep_mode    (sleep_mode),
    .demand        (demand),
    .use_powersave (use_ps)
  );

  // Address decode and read data; unmapped addresses answer with an error and zero data.
  always_comb begin
    mapped    = 1'b1;
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      vref_pkg::ADDR_CTRL: begin
        rdata_nxt[vref_pkg::CTRL_READY_BIT]                     = vref_pkg::READY_LEVEL;
        rdata_nxt[vref_pkg::CTRL_EN_BIT]                        = ctrl_r.ref_enable;
        rdata_nxt[vref_pkg::CTRL_TS_BIT]                        = ctrl_r.temp_sense_enable;
        rdata_nxt[vref_pkg::CTRL_RNG_BIT]                       = ctrl_r.temp_range_select;
        rdata_nxt[vref_pkg::CTRL_GAIN_LSB +: 2]                 = ctrl_r.gain;
      end
      vref_pkg::ADDR_CFG: begin
        rdata_nxt[vref_pkg::CFG_BOR_LSB +: 2]        = cfg_r.brownout_enable_cfg;
        rdata_nxt[vref_pkg::CFG_FAST_BIT]            = cfg_r.brownout_fast_start;
        rdata_nxt[vref_pkg::CFG_PS_BIT]              = cfg_r.regulator_powersave_select;
      end
      vref_pkg::ADDR_STAT: begin
        rdata_nxt[vref_pkg::STAT_ACTIVE_BIT] = ref_active_r;
        rdata_nxt[vref_pkg::STAT_SW_BIT]     = demand.sw;
        rdata_nxt[vref_pkg::STAT_BOR_BIT]    = demand.brownout;
        rdata_nxt[vref_pkg::STAT_REG_BIT]    = demand.regulator;
        rdata_nxt[vref_pkg::STAT_PS_BIT]     = powersave_r;
        rdata_nxt[vref_pkg::STAT_ROUTE_BIT]  = adc_ref_route_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // A write lands at the edge where the master sees pready high, never earlier.
  assign wr_done = psel && penable && pready_r && pwrite && !pslverr_r;

  // One wait state keeps every bus output on a flip-flop at the cost of a cycle per access.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      pready_r  <= 1'b1;
      prdata_r  <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr_r <= !mapped;
    end else begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // Control register; the ready bit and bits 3 and 2 have no storage.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= vref_pkg::vref_ctrl_t'(5'(vref_pkg::CTRL_RESET));
    end else if (wr_done && paddr == vref_pkg::ADDR_CTRL && pstrb[0]) begin
      ctrl_r.ref_enable        <= pwdata[vref_pkg::CTRL_EN_BIT];
      ctrl_r.temp_sense_enable <= pwdata[vref_pkg::CTRL_TS_BIT];
      ctrl_r.temp_range_select <= pwdata[vref_pkg::CTRL_RNG_BIT];
      ctrl_r.gain <= vref_pkg::vref_gain_t'(pwdata[vref_pkg::CTRL_GAIN_LSB +: 2]);
    end
  end

  // Brown-out and regulator configuration register.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= vref_pkg::vref_cfg_t'(vref_pkg::CFG_RESET);
    end else if (wr_done && paddr == vref_pkg::ADDR_CFG && pstrb[0]) begin
      cfg_r.brownout_enable_cfg        <= pwdata[vref_pkg::CFG_BOR_LSB +: 2];
      cfg_r.brownout_fast_start        <= pwdata[vref_pkg::CFG_FAST_BIT];
      cfg_r.regulator_powersave_select <= pwdata[vref_pkg::CFG_PS_BIT];
    end
  end

  // Reference power: any requester keeps it on; with none it turns off.
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_active_r <= 1'b0;
      powersave_r  <= 1'b0;
    end else begin
      ref_active_r <= |demand;
      powersave_r  <= use_ps;
    end
  end

  // Output buffer toward the ADC; code zero switches it off even with the reference running.
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_out_en_r    <= 1'b0;
      ref_gain_r      <= vref_pkg::GAIN_OFF;
      adc_ref_route_r <= 1'b0;
    end else begin
      ref_out_en_r    <= (ctrl_r.gain != vref_pkg::GAIN_OFF);
      ref_gain_r      <= ctrl_r.gain;
      adc_ref_route_r <= (adc_chan_sel == ADC_REF_CHANNEL);
    end
  end

  // Temperature indicator bias; cleared enable means zero current in the analog cell.
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_sense_on_r   <= 1'b0;
      temp_range_high_r <= 1'b0;
    end else begin
      temp_sense_on_r   <= ctrl_r.temp_sense_enable;
      temp_range_high_r <= ctrl_r.temp_range_select;
    end
  end

  // Ports driven straight from flip-flops.
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign ref_active        = ref_active_r;
  assign ref_out_en        = ref_out_en_r;
  assign ref_gain          = ref_gain_r;
  assign adc_ref_route     = adc_ref_route_r;
  assign temp_sense_on     = temp_sense_on_r;
  assign temp_range_high   = temp_range_high_r;
  assign powersave_reg_sel = powersave_r;

  // Software enable alone turns the reference on one cycle later.
  property p_sw_on;
    @(posedge clk) disable iff (rst) ctrl_r.ref_enable |=> ref_active_r;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("Enable set but reference off.");

  // With no requester at all the reference must be off.
  property p_all_off;
    @(posedge clk) disable iff (rst) (demand == 3'b000) |=> !ref_active_r;
  endproperty
  a_all_off: assert property (p_all_off) else $error("Reference on with no demand.");

  // Brown-out always-on or off-in-sleep with fast start forces the reference.
  property p_bor_force;
    @(posedge clk) disable iff (rst)
      (cfg_r.brownout_enable_cfg == vref_pkg::BOR_ALWAYS ||
       (cfg_r.brownout_enable_cfg == vref_pkg::BOR_NO_SLEEP && cfg_r.brownout_fast_start))
      |=> ref_active_r;
  endproperty
  a_bor_force: assert property (p_bor_force) else $error("Brown-out demand ignored.");

  // Software-controlled brown-out with fast start also forces it.
  property p_bor_sw;
    @(posedge clk) disable iff (rst)
      (cfg_r.brownout_enable_cfg == vref_pkg::BOR_SW_CTRL && cfg_r.brownout_fast_start)
      |=> ref_active_r;
  endproperty
  a_bor_sw: assert property (p_bor_sw) else $error("Fast-start brown-out demand ignored.");

  // Regulator demand holds only while awake.
  property p_reg;
    @(posedge clk) disable iff (rst)
      (cfg_r.regulator_powersave_select && !sleep_mode) |=> ref_active_r;
  endproperty
  a_reg: assert property (p_reg) else $error("Regulator demand ignored.");

  // Sleep selects the power-save regulator in the next cycle.
  property p_sleep_ps;
    @(posedge clk) disable iff (rst) sleep_mode |=> (powersave_reg_sel == $past(sleep_mode));
  endproperty
  a_sleep_ps: assert property (p_sleep_ps) else $error("Sleep without power-save regulator.");

  // The ADC sees the reference exactly when its channel is selected.
  property p_route;
    @(posedge clk) disable iff (rst)
      ##1 adc_ref_route == ($past(adc_chan_sel) == ADC_REF_CHANNEL);
  endproperty
  a_route: assert property (p_route) else $error("ADC reference routing wrong.");

  // A control read returns the documented layout with bits 3 and 2 at zero.
  property p_ctrl_read;
    @(posedge clk) disable iff (rst)
      ($rose(pready_r) && !pwrite && paddr == vref_pkg::ADDR_CTRL)
      |-> (prdata_r[7:0] == {vref_pkg::READY_LEVEL, $past(ctrl_r.ref_enable),
                             $past(ctrl_r.temp_sense_enable), $past(ctrl_r.temp_range_select),
                             2'h0, $past(ctrl_r.gain)});
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("Control read layout wrong.");

  // Gain code zero keeps the ADC output buffer off; any other code turns it on.
  property p_gain;
    @(posedge clk) disable iff (rst)
      ##1 ref_out_en == ($past(ctrl_r.gain) != vref_pkg::GAIN_OFF);
  endproperty
  a_gain: assert property (p_gain) else $error("Gain output enable wrong.");

  // Indicator enable and range follow their bits one cycle later.
  property p_temp;
    @(posedge clk) disable iff (rst)
      ##1 (temp_sense_on == $past(ctrl_r.temp_sense_enable)) &&
          (temp_range_high == $past(ctrl_r.temp_range_select));
  endproperty
  a_temp: assert property (p_temp) else $error("Temperature indicator control wrong.");

  // Writing a one to the enable bit stores it at the completing edge.
  property p_en_set;
    @(posedge clk) disable iff (rst)
      (wr_done && paddr == vref_pkg::ADDR_CTRL && pstrb[0] && pwdata[vref_pkg::CTRL_EN_BIT])
      |=> ctrl_r.ref_enable;
  endproperty
  a_en_set: assert property (p_en_set) else $error("Enable write lost.");

  // Writing a zero to the enable bit clears it, so only forced demand can keep power on.
  property p_en_clr;
    @(posedge clk) disable iff (rst)
      (wr_done && paddr == vref_pkg::ADDR_CTRL && pstrb[0] && !pwdata[vref_pkg::CTRL_EN_BIT])
      |=> !ctrl_r.ref_enable;
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("Enable clear lost.");

  // Bits 3 and 2 and every bit above the byte read back as zero.
  property p_ctrl_gap;
    @(posedge clk) disable iff (rst)
      (pready_r && !pwrite && paddr == vref_pkg::ADDR_CTRL)
      |-> (prdata_r[vref_pkg::CTRL_GAP_LSB +: 2] == 2'h0) &&
          (prdata_r[31:vref_pkg::CTRL_READY_BIT + 1] == 24'h00_0000);
  endproperty
  a_ctrl_gap: assert property (p_ctrl_gap) else $error("Unused bits not zero.");

  // Waking up hands the core back to the main regulator path one cycle later.
  property p_wake_main;
    @(posedge clk) disable iff (rst) !sleep_mode |=> !powersave_reg_sel;
  endproperty
  a_wake_main: assert property (p_wake_main) else $error("Wake not honoured.");

  // Sleep withdraws the regulator demand, so with no other requester the reference drops.
  property p_reg_sleep;
    @(posedge clk) disable iff (rst)
      (sleep_mode && !demand.sw && !demand.brownout) |=> !ref_active_r;
  endproperty
  a_reg_sleep: assert property (p_reg_sleep) else $error("Held in sleep.");

  // The gain code reaches the output buffer unchanged one cycle later.
  property p_gain_level;
    @(posedge clk) disable iff (rst) ##1 ref_gain == $past(ctrl_r.gain);
  endproperty
  a_gain_level: assert property (p_gain_level) else $error("Gain level wrong.");

  // A cleared indicator enable leaves the analog cell unbiased in the next cycle.
  property p_temp_off;
    @(posedge clk) disable iff (rst) !ctrl_r.temp_sense_enable |=> !temp_sense_on;
  endproperty
  a_temp_off: assert property (p_temp_off) else $error("Indicator left on.");

  // A cleared range bit falls back to the low range, which suits low supply voltages.
  property p_range_low;
    @(posedge clk) disable iff (rst) !ctrl_r.temp_range_select |=> !temp_range_high;
  endproperty
  a_range_low: assert property (p_range_low) else $error("Range left high.");

endmodule : vref_ctrl

// ---- verification/tb_fixed_voltage_ref_control.sv ----
// Self-checking bench for the fixed reference control block, driven over APB.
// Assumes vref_ctrl and vref_pkg are compiled first; one 50 MHz clock.
module tb_fixed_voltage_ref_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk;
  logic                 rst;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [3:0]           pstrb;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 sleep_mode;
  logic [3:0]           adc_chan_sel;
  logic                 ref_active;
  logic                 ref_out_en;
  vref_pkg::vref_gain_t ref_gain;
  logic                 adc_ref_route;
  logic                 temp_sense_on;
  logic                 temp_range_high;
  logic                 powersave_reg_sel;
  int                   n_fail;
  int                   samples_checked;
  logic [31:0]          rd;
  logic                 er;

  vref_ctrl vref_ctrl_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .adc_chan_sel(adc_chan_sel), .ref_active(ref_active), .ref_out_en(ref_out_en),
    .ref_gain(ref_gain), .adc_ref_route(adc_ref_route), .temp_sense_on(temp_sense_on),
    .temp_range_high(temp_range_high), .powersave_reg_sel(powersave_reg_sel)
  );

  // Free-running clock, 20 ns period.
  always #10 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // One comparison; case inequality so an unknown never matches.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("wrong value pready expected 1 seen %b", pready);
      n_fail++;
      conclude();
    end
  endtask : apb

  // Lets registered outputs settle after a register or input change.
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle

  // Register fields: placement, unused bits, ready flag and the derived controls.
  task automatic t_ctrl_fields;
    logic [7:0] wd;
    logic [7:0] ex;
    apb(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, rd, er);
    chk("ctrl reset", 32'h0000_0080, rd);
    chk("ctrl pslverr", 32'h0, {31'h0, er});
    for (int k = 0; k < 32; k++) begin
      wd = {1'b0, k[4], k[3], k[2], 2'b11, k[1:0]};
      ex = {1'b1, k[4], k[3], k[2], 2'b00, k[1:0]};
      apb(1'b1, vref_pkg::ADDR_CTRL, {24'h0, wd}, 4'hF, rd, er);
      apb(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, rd, er);
      chk("ctrl readback", {24'h0, ex}, rd);
      settle();
      chk("ref_active", {31'h0, k[4]}, {31'h0, ref_active});
      chk("temp_sense_on", {31'h0, k[3]}, {31'h0, temp_sense_on});
      chk("temp_range_high", {31'h0, k[2]}, {31'h0, temp_range_high});
      chk("ref_gain", {30'h0, k[1:0]}, {30'h0, ref_gain});
      chk("ref_out_en", {31'h0, (k[1:0] != 2'h0)}, {31'h0, ref_out_en});
    end
    // A write with the low byte lane disabled must leave the register alone.
    apb(1'b1, vref_pkg::ADDR_CTRL, 32'h0, 4'hE, rd, er);
    apb(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, rd, er);
    chk("ctrl strobe", 32'h0000_00F3, rd);
    apb(1'b1, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, rd, er);
    $display("test ctrl_fields done");
  endtask : t_ctrl_fields

  // Every brown-out code, fast start, power-save select and sleep combination.
  task automatic t_demand;
    logic exp;
    logic bor_need;
    logic reg_need;
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, vref_pkg::ADDR_CFG, {28'h0, i[3:0]}, 4'hF, rd, er);
      @(posedge clk);
      sleep_mode <= i[4];
      settle();
      bor_need = (i[1:0] == 2'h3) || (i[1:0] != 2'h0 && i[2]);
      reg_need = i[3] && !i[4];
      exp = bor_need || reg_need;
      chk("forced ref_active", {31'h0, exp}, {31'h0, ref_active});
      chk("powersave_reg_sel", {31'h0, i[4]}, {31'h0, powersave_reg_sel});
      apb(1'b0, vref_pkg::ADDR_CFG, 32'h0, 4'hF, rd, er);
      chk("cfg readback", {28'h0, i[3:0]}, rd);
      apb(1'b0, vref_pkg::ADDR_STAT, 32'h0, 4'hF, rd, er);
      chk("status", {26'h0, 1'b0, i[4], reg_need, bor_need, 1'b0, exp}, rd);
    end
    apb(1'b1, vref_pkg::ADDR_CFG, 32'h0, 4'hF, rd, er);
    sleep_mode <= 1'b0;
    $display("test demand done");
  endtask : t_demand

  // The reference reaches the ADC only on its own channel.
  task automatic t_adc_route;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      adc_chan_sel <= c[3:0];
      settle();
      chk("adc_ref_route", {31'h0, (c == 15)}, {31'h0, adc_ref_route});
    end
    $display("test adc_route done");
  endtask : t_adc_route

  // Unmapped addresses answer with an error and no data.
  task automatic t_unmapped;
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF, 4'hF, rd, er);
    chk("write pslverr", 32'h1, {31'h0, er});
    apb(1'b0, 12'h00C, 32'h0, 4'hF, rd, er);
    chk("read pslverr", 32'h1, {31'h0, er});
    chk("read prdata", 32'h0, rd);
    apb(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, rd, er);
    chk("ctrl after error", 32'h0000_0080, rd);
    $display("test unmapped done");
  endtask : t_unmapped

  // Reset for 8 cycles, then run the scenarios in turn.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    sleep_mode = 1'b0;
    adc_chan_sel = 4'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_ctrl_fields();
    t_demand();
    t_adc_route();
    t_unmapped();
    conclude();
  end

endmodule : tb_fixed_voltage_ref_control
